//--- common/ldcr_pkg.sv
// Purpose: shared constants for the LED driver configuration register bank
// Assumes: 16-bit registers at byte offsets on the serial control interface
// Notes:   lookup functions turn field codes into physical units
package ldcr_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam logic [7:0]  OFS_BRT    = 8'h00;
	localparam logic [7:0]  OFS_DIM    = 8'h04;
	localparam logic [7:0]  OFS_FAULT  = 8'h06;
	localparam logic [7:0]  OFS_SUPPLY = 8'h08;

	localparam logic [15:0] BRT_RST    = 16'h0000;
	localparam logic [15:0] DIM_RST    = 16'h08A3;
	localparam logic [15:0] FAULT_RST  = 16'h0100;
	localparam logic [15:0] SUPPLY_RST = 16'h2AAA;

	////////////////////////////////////////////////////////////////////////
	// dimming options field positions
	localparam int POS_PSEUDO = 14;
	localparam int POS_RATE   = 12;
	localparam int POS_RANGE  = 10;
	localparam int POS_SRC    = 8;
	localparam int POS_SLOPE  = 5;
	localparam int POS_DITHER = 2;
	localparam int POS_SMOOTH = 1;
	// fault detect options field positions
	localparam int POS_GND    = 8;
	localparam int POS_STRING = 0;
	// supply mask: two-bit fields from bit 0 upward, sync loss is the top one
	localparam int IRQ_FIELDS   = 7;
	localparam int IRQ_SYNC_IDX = 6;

	localparam logic [1:0] SRC_PIN    = 2'h0;
	localparam logic [1:0] SRC_REG    = 2'h2;
	localparam logic [1:0] IRQ_WR_OFF = 2'h1;
	localparam logic [1:0] IRQ_WR_ON  = 2'h3;
	localparam logic [1:0] IRQ_RD_OFF = 2'h0;
	localparam logic [1:0] IRQ_RD_ON  = 2'h2;

	// duty measurement window, in log2 of clock cycles
	localparam int DUTY_WIN_BITS = 16;
	localparam int DUTY_BITS     = 16;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [10:0] rate_hz(input logic [1:0] code);
		unique case (code)
			2'h0: rate_hz = 11'd200;
			2'h1: rate_hz = 11'd500;
			2'h2: rate_hz = 11'd800;
			2'h3: rate_hz = 11'd1200;
		endcase
	endfunction : rate_hz

	// spread in tenths of a percent
	function automatic logic [6:0] range_tenths(input logic [1:0] code);
		unique case (code)
			2'h0: range_tenths = 7'd33;
			2'h1: range_tenths = 7'd43;
			2'h2: range_tenths = 7'd53;
			2'h3: range_tenths = 7'd72;
		endcase
	endfunction : range_tenths

	function automatic logic [9:0] slope_ms(input logic [2:0] code);
		unique case (code)
			3'h0: slope_ms = 10'd0;
			3'h1: slope_ms = 10'd1;
			3'h2: slope_ms = 10'd2;
			3'h3: slope_ms = 10'd50;
			3'h4: slope_ms = 10'd100;
			3'h5: slope_ms = 10'd200;
			3'h6: slope_ms = 10'd300;
			3'h7: slope_ms = 10'd500;
		endcase
	endfunction : slope_ms

endpackage : ldcr_pkg

//--- hw/ldcr_irq_field.sv
// Purpose: one two-bit interrupt enable field with set/clear write codes
// Assumes: wr_stb is a one-cycle strobe from the register decoder
// Notes:   codes other than the two command codes leave the state alone
`timescale 1ns/1ps
`default_nettype none
module ldcr_irq_field #(
	parameter bit RST_ON = 1'b1
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       ce,
	input  wire logic       wr_stb,
	input  wire logic [1:0] wr_code,
	output logic            enabled,
	output logic      [1:0] rd_code
);

	logic on_r;
	logic on_nxt;

	always_comb begin
		on_nxt = on_r;
		if (wr_stb) begin
			if (wr_code == ldcr_pkg::IRQ_WR_ON)
				on_nxt = 1'b1;
			else if (wr_code == ldcr_pkg::IRQ_WR_OFF)
				on_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			on_r <= RST_ON;
		else if (ce)
			on_r <= on_nxt;
	end

	assign enabled = on_r;
	assign rd_code = on_r ? ldcr_pkg::IRQ_RD_ON : ldcr_pkg::IRQ_RD_OFF;

endmodule : ldcr_irq_field
`default_nettype wire

//--- hw/ldcr_regs.sv
// Purpose: configuration register bank of a four-string LED backlight driver
// Assumes: one clock; pwm_pin is asynchronous; reg port is same-clock
// Notes:   read data is registered one cycle after reg_rd
`timescale 1ns/1ps
`default_nettype none
module ldcr_regs #(
	parameter int DUTY_WIN_BITS = ldcr_pkg::DUTY_WIN_BITS
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        ce,
	input  wire logic        pwm_pin,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             spread_pseudo_on,
	output logic      [1:0]  spread_rate_sel,
	output logic      [10:0] spread_rate_hz,
	output logic      [1:0]  spread_range_sel,
	output logic      [6:0]  spread_range_tenths,
	output logic      [1:0]  brightness_source_sel,
	output logic      [15:0] brightness_value,
	output logic      [2:0]  slope_time_sel,
	output logic      [9:0]  slope_time_ms,
	output logic      [2:0]  dither_sel,
	output logic             smooth_ramp_on,
	output logic             ground_short_check_on,
	output logic      [3:0]  string_short_off,
	output logic      [6:0]  supply_irq_on,
	output logic             sync_loss_irq_on,
	output logic      [15:0] pwm_duty
);

	////////////////////////////////////////////////////////////////////////
	logic [15:0] brightness_level_r, brightness_level_nxt;
	logic [15:0] dim_r,              dim_nxt;
	logic [15:0] fault_r,            fault_nxt;
	logic [15:0] rdata_r,            rdata_nxt;
	logic [10:0] hz_r,               hz_nxt;
	logic [6:0]  tenths_r,           tenths_nxt;
	logic [9:0]  ms_r,               ms_nxt;
	logic [15:0] bval_r,             bval_nxt;
	logic [15:0] supply_rd;
	logic        sup_wr;

	assign sup_wr = reg_wr && reg_addr == ldcr_pkg::OFS_SUPPLY;

	// supply mask fields share one encoding, so one instance per field
	genvar gi;
	generate
		for (gi = 0; gi < ldcr_pkg::IRQ_FIELDS; gi++) begin : g_irq
			ldcr_irq_field #(
				.RST_ON (ldcr_pkg::SUPPLY_RST[2*gi+1])
			) u_field (
				.clk     (clk),
				.reset   (reset),
				.ce      (ce),
				.wr_stb  (sup_wr),
				.wr_code (reg_wdata[2*gi+1:2*gi]),
				.enabled (supply_irq_on[gi]),
				.rd_code (supply_rd[2*gi+1:2*gi])
			);
		end
	endgenerate
	// upper two bits are reserved and read back zero
	assign supply_rd[15:14] = 2'h0;
	assign sync_loss_irq_on = supply_irq_on[ldcr_pkg::IRQ_SYNC_IDX];

	////////////////////////////////////////////////////////////////////////
	// pin duty measurement over a window of 2**DUTY_WIN_BITS cycles
	logic                     pin_meta_r, pin_sync_r;
	logic [DUTY_WIN_BITS-1:0] win_r,  win_nxt;
	logic [DUTY_WIN_BITS-1:0] high_r, high_nxt;
	logic [15:0]              duty_r, duty_nxt;
	logic [DUTY_WIN_BITS-1:0] total;

	always_comb begin
		total    = high_r + DUTY_WIN_BITS'(pin_sync_r);
		win_nxt  = win_r + DUTY_WIN_BITS'(1);
		high_nxt = total;
		duty_nxt = duty_r;
		if (&win_r) begin
			high_nxt = '0;
			// full-high window would wrap, so saturate
			if (&high_r && pin_sync_r)
				duty_nxt = 16'hFFFF;
			else
				duty_nxt = 16'(total) << (ldcr_pkg::DUTY_BITS - DUTY_WIN_BITS);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_meta_r <= 1'b0;
			pin_sync_r <= 1'b0;
			win_r      <= '0;
			high_r     <= '0;
			duty_r     <= 16'h0000;
		end else if (ce) begin
			pin_meta_r <= pwm_pin;
			pin_sync_r <= pin_meta_r;
			win_r      <= win_nxt;
			high_r     <= high_nxt;
			duty_r     <= duty_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		brightness_level_nxt = brightness_level_r;
		dim_nxt              = dim_r;
		fault_nxt            = fault_r;
		rdata_nxt            = rdata_r;
		if (reg_wr) begin
			unique case (reg_addr)
				ldcr_pkg::OFS_BRT:   brightness_level_nxt = reg_wdata;
				ldcr_pkg::OFS_DIM:   dim_nxt = reg_wdata;
				ldcr_pkg::OFS_FAULT: fault_nxt = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				ldcr_pkg::OFS_BRT:    rdata_nxt = brightness_level_r;
				ldcr_pkg::OFS_DIM:    rdata_nxt = dim_r;
				ldcr_pkg::OFS_FAULT:  rdata_nxt = fault_r;
				ldcr_pkg::OFS_SUPPLY: rdata_nxt = supply_rd;
				default:              rdata_nxt = 16'h0000;
			endcase
		end
		hz_nxt     = ldcr_pkg::rate_hz(dim_nxt[ldcr_pkg::POS_RATE +: 2]);
		tenths_nxt = ldcr_pkg::range_tenths(dim_nxt[ldcr_pkg::POS_RANGE +: 2]);
		// linear-mode time; smoothing is added downstream when advanced
		ms_nxt     = ldcr_pkg::slope_ms(dim_nxt[ldcr_pkg::POS_SLOPE +: 3]);
		// reserved source codes fall back to the pin
		if (dim_nxt[ldcr_pkg::POS_SRC +: 2] == ldcr_pkg::SRC_REG)
			bval_nxt = brightness_level_nxt;
		else
			bval_nxt = duty_nxt;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			brightness_level_r <= ldcr_pkg::BRT_RST;
			dim_r              <= ldcr_pkg::DIM_RST;
			fault_r            <= ldcr_pkg::FAULT_RST;
			rdata_r            <= 16'h0000;
			hz_r               <= 11'd200;
			tenths_r           <= 7'd53;
			ms_r               <= 10'd200;
			bval_r             <= 16'h0000;
		end else if (ce) begin
			brightness_level_r <= brightness_level_nxt;
			dim_r              <= dim_nxt;
			fault_r            <= fault_nxt;
			rdata_r            <= rdata_nxt;
			hz_r               <= hz_nxt;
			tenths_r           <= tenths_nxt;
			ms_r               <= ms_nxt;
			bval_r             <= bval_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign reg_rdata             = rdata_r;
	assign spread_pseudo_on      = dim_r[ldcr_pkg::POS_PSEUDO];
	assign spread_rate_sel       = dim_r[ldcr_pkg::POS_RATE +: 2];
	assign spread_rate_hz        = hz_r;
	assign spread_range_sel      = dim_r[ldcr_pkg::POS_RANGE +: 2];
	assign spread_range_tenths   = tenths_r;
	assign brightness_source_sel = dim_r[ldcr_pkg::POS_SRC +: 2];
	assign brightness_value      = bval_r;
	assign slope_time_sel        = dim_r[ldcr_pkg::POS_SLOPE +: 3];
	assign slope_time_ms         = ms_r;
	assign dither_sel            = dim_r[ldcr_pkg::POS_DITHER +: 3];
	assign smooth_ramp_on        = dim_r[ldcr_pkg::POS_SMOOTH];
	assign ground_short_check_on = fault_r[ldcr_pkg::POS_GND];
	// bits 7-4 are stored as written; keeping them zero is the host's job
	assign string_short_off      = fault_r[ldcr_pkg::POS_STRING +: 4];
	assign pwm_duty              = duty_r;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_dim_wr;
		ce && reg_wr && reg_addr == ldcr_pkg::OFS_DIM;
	endsequence
	sequence s_fault_wr;
		ce && reg_wr && reg_addr == ldcr_pkg::OFS_FAULT;
	endsequence
	sequence s_sup_wr(logic [1:0] code);
		ce && reg_wr && reg_addr == ldcr_pkg::OFS_SUPPLY && reg_wdata[13:12] == code;
	endsequence

	a_pseudo_write: assert property (s_dim_wr |=> spread_pseudo_on == $past(reg_wdata[14]))
		else $error("pseudo spread enable not taken from write");
	a_rate_top: assert property (s_dim_wr ##0 reg_wdata[13:12] == 2'h3 |=> spread_rate_hz == 11'd1200)
		else $error("rate code 3 not 1200 Hz");
	a_range_low: assert property (s_dim_wr ##0 reg_wdata[11:10] == 2'h0 |=> spread_range_tenths == 7'd33)
		else $error("range code 0 not 3.3 percent");
	a_src_register: assert property (ce && !reg_wr && brightness_source_sel == ldcr_pkg::SRC_REG
		|=> brightness_value == $past(brightness_level_r))
		else $error("register source not followed");
	a_slope_max: assert property (s_dim_wr ##0 reg_wdata[7:5] == 3'h7 |=> slope_time_ms == 10'd500 && slope_time_sel == 3'h7)
		else $error("slope code 7 not 500 ms");
	a_dither_smooth: assert property (s_dim_wr |=> dither_sel == $past(reg_wdata[4:2]) && smooth_ramp_on == $past(reg_wdata[1]))
		else $error("dither or sloping style not taken");
	a_fault_fields: assert property (s_fault_wr |=> ground_short_check_on == $past(reg_wdata[8])
		&& string_short_off == $past(reg_wdata[3:0]))
		else $error("fault detect fields not taken");
	a_reset_values: assert property ($fell(reset) |-> fault_r == 16'h0100 && sync_loss_irq_on && dim_r == 16'h08A3)
		else $error("reset values wrong");
	// set and clear kept apart: an or between two implications binds wrongly
	a_irq_set: assert property (s_sup_wr(2'h3) |=> sync_loss_irq_on)
		else $error("enable command not applied");
	a_irq_clear: assert property (s_sup_wr(2'h1) |=> !sync_loss_irq_on)
		else $error("disable command not applied");
	a_irq_ignore: assert property (s_sup_wr(2'h0) or s_sup_wr(2'h2) |=> $stable(sync_loss_irq_on))
		else $error("ignored code changed enable");
	a_irq_read: assert property (ce && reg_rd && !reg_wr && reg_addr == ldcr_pkg::OFS_SUPPLY
		|=> reg_rdata[13:12] == (sync_loss_irq_on ? 2'h2 : 2'h0))
		else $error("enable field read code wrong");
	a_duty_full: assert property (ce && &win_r && &high_r && pin_sync_r |=> pwm_duty == 16'hFFFF)
		else $error("full-high window not saturated");

endmodule : ldcr_regs
`default_nettype wire

//--- verif/ldcr_host.sv
// Purpose: host model that drives the register port of the bank
// Assumes: requests launched at the falling edge, taken at the next rising edge
// Notes:   idle address and data show the inverse so stale values cannot match
`timescale 1ns/1ps
`default_nettype none
module ldcr_host (
	input  wire logic        clk,
	input  wire logic [15:0] reg_rdata,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [7:0]  reg_addr,
	output logic      [15:0] reg_wdata
);
	initial begin
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 8'hFF;
		reg_wdata = 16'h0000;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_wr    = 1'b1;
		reg_addr  = a;
		reg_wdata = (a == ldcr_pkg::OFS_FAULT) ? (d & 16'hFF0F) : d;
		@(negedge clk);
		reg_wr    = 1'b0;
		reg_addr  = ~a;
		reg_wdata = ~reg_wdata;
	endtask : wr
	// read data is taken one edge after the request
	task automatic rd(input logic [7:0] a, output logic [15:0] r);
		@(negedge clk);
		reg_rd   = 1'b1;
		reg_addr = a;
		@(negedge clk);
		r        = reg_rdata;
		reg_rd   = 1'b0;
		reg_addr = ~a;
	endtask : rd
endmodule : ldcr_host
`default_nettype wire

//--- verif/ldcr_regs_bench.sv
// Purpose: self-checking bench for the configuration register bank
// Assumes: short duty window (4 bits) so saturation shows quickly
// Notes:   pwm pin stays low until the duty scenario, so duty is zero before
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module ldcr_regs_bench;
	localparam logic [10:0] HZ_T [4] = '{11'h0C8, 11'h1F4, 11'h320, 11'h4B0};
	localparam logic [6:0]  TN_T [4] = '{7'h21, 7'h2B, 7'h35, 7'h48};
	localparam logic [9:0]  MS_T [8] = '{10'h000, 10'h001, 10'h002, 10'h032,
		10'h064, 10'h0C8, 10'h12C, 10'h1F4};
	logic clk, reset, ce, pwm_pin, reg_wr, reg_rd, spread_pseudo_on, smooth_ramp_on;
	logic ground_short_check_on, sync_loss_irq_on;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, brightness_value, pwm_duty, d, r, bright, last;
	logic [10:0] spread_rate_hz;
	logic [6:0]  spread_range_tenths, supply_irq_on, m;
	logic [1:0]  spread_rate_sel, spread_range_sel, brightness_source_sel;
	logic [2:0]  slope_time_sel, dither_sel;
	logic [9:0]  slope_time_ms;
	logic [3:0]  string_short_off;
	int comparisons, n_mismatch, cycles, seed;

	ldcr_regs #(.DUTY_WIN_BITS(4)) i_dut (.clk, .reset, .ce, .pwm_pin, .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata, .reg_rdata, .spread_pseudo_on, .spread_rate_sel,
		.spread_rate_hz, .spread_range_sel, .spread_range_tenths, .brightness_source_sel,
		.brightness_value, .slope_time_sel, .slope_time_ms, .dither_sel, .smooth_ramp_on,
		.ground_short_check_on, .string_short_off, .supply_irq_on, .sync_loss_irq_on,
		.pwm_duty);
	ldcr_host i_host (.clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [6:0] irq_next(input logic [6:0] s, input logic [15:0] w);
		for (int f = 0; f < 7; f++) begin
			if (w[2*f+:2] == 2'h1) s[f] = 1'b0;
			else if (w[2*f+:2] == 2'h3) s[f] = 1'b1;
		end
		return s;
	endfunction : irq_next
	function automatic logic [15:0] mask_rd(input logic [6:0] s);
		logic [15:0] v;
		v = 16'h0000;
		for (int f = 0; f < 7; f++) v[2*f+1] = s[f];
		return v;
	endfunction : mask_rd
	task automatic check_dim(input logic [15:0] w);
		i_host.rd(ldcr_pkg::OFS_DIM, r);
		`CHK(r, w)
		`CHK(spread_pseudo_on, w[14])
		`CHK(spread_rate_sel, w[13:12])
		`CHK(spread_rate_hz, HZ_T[w[13:12]])
		`CHK(spread_range_sel, w[11:10])
		`CHK(spread_range_tenths, TN_T[w[11:10]])
		`CHK(brightness_source_sel, w[9:8])
		// pin is held low whenever this task runs, so pin duty must read zero
		`CHK(brightness_value, (w[9:8] == 2'h2) ? bright : 16'h0000)
		`CHK(slope_time_sel, w[7:5])
		`CHK(slope_time_ms, MS_T[w[7:5]])
		`CHK(dither_sel, w[4:2])
		`CHK(smooth_ramp_on, w[1])
	endtask : check_dim
	task automatic check_reset();
		check_dim(16'h08A3);
		i_host.rd(ldcr_pkg::OFS_FAULT, r);
		`CHK(r, 16'h0100)
		`CHK(ground_short_check_on, 1'b1)
		`CHK(string_short_off, 4'h0)
		i_host.rd(ldcr_pkg::OFS_SUPPLY, r);
		`CHK(r, 16'h2AAA)
		`CHK(sync_loss_irq_on, 1'b1)
	endtask : check_reset
	task automatic final_report();
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h02EB34A2;
		clk = 1'b0;
		reset = 1'b1;
		ce = 1'b1;
		pwm_pin = 1'b0;
		bright = 16'h0000;
		m = 7'h7F;
		repeat (10) @(posedge clk);
		@(negedge clk) reset = 1'b0;
		check_reset();
		bright = 16'($random(seed));
		i_host.wr(ldcr_pkg::OFS_BRT, bright);
		for (int i = 0; i < 24; i++) begin
			d = 16'($random(seed));
			// walk every code of the rate, range, source and slope fields first
			if (i < 8) d[13:5] = {i[1:0], i[1:0], i[1:0], i[2:0]};
			i_host.wr(ldcr_pkg::OFS_DIM, d);
			check_dim(d);
		end
		last = d;
		for (int i = 0; i < 8; i++) begin
			d = 16'($random(seed)) & 16'hFF0F;
			i_host.wr(ldcr_pkg::OFS_FAULT, d);
			i_host.rd(ldcr_pkg::OFS_FAULT, r);
			`CHK(r, d)
			`CHK(ground_short_check_on, d[8])
			`CHK(string_short_off, d[3:0])
		end
		for (int i = 0; i < 16; i++) begin
			d = 16'($random(seed));
			i_host.wr(ldcr_pkg::OFS_SUPPLY, d);
			m = irq_next(m, d);
			i_host.rd(ldcr_pkg::OFS_SUPPLY, r);
			`CHK(r, mask_rd(m))
			`CHK(supply_irq_on, m)
			`CHK(sync_loss_irq_on, m[6])
		end
		i_host.wr(8'h0A, 16'hFFFF);
		i_host.rd(8'h0A, r);
		`CHK(r, 16'h0000)
		check_dim(last);
		@(negedge clk) ce = 1'b0;
		i_host.wr(ldcr_pkg::OFS_DIM, ~last);
		ce = 1'b1;
		check_dim(last);
		i_host.wr(ldcr_pkg::OFS_DIM, 16'h08A3);
		pwm_pin = 1'b1;
		repeat (52) @(negedge clk);
		`CHK(pwm_duty, 16'hFFFF)
		`CHK(brightness_value, 16'hFFFF)
		pwm_pin = 1'b0;
		repeat (52) @(negedge clk);
		`CHK(pwm_duty, 16'h0000)
		reset = 1'b1;
		@(negedge clk) reset = 1'b0;
		check_reset();
		final_report();
	end
endmodule : ldcr_regs_bench
`default_nettype wire
